//--- src/dat_ack_gen.sv
`timescale 1ns/1ps
`default_nettype none

`include "dat_consts.svh"

// dma acknowledge output timing.
// all qualifying inputs describe the bus cycle that begins at the next
// rising edge; the sequencer knows its next state, so the ack flop lands
// exactly on the start of the address output.
module dat_ack_gen
   import dat_pkg::*;
#(
   parameter int NUM_CH = `DAT_NUM_CH,
   parameter int CH_W   = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
)
(
   input  wire logic              ref_clk_in,          // bus clock, 125 MHz
   input  wire logic              srst_in,             // sync reset, high
   input  wire logic [NUM_CH-1:0] ack_cycle_select_in, // per ch: 0 read, 1 write
   input  wire logic              single_addr_mode_in, // single address mode
   input  wire logic              dma_cycle_in,        // next cycle is a dma cycle
   input  wire logic [CH_W-1:0]   dma_channel_in,      // channel owning it
   input  wire logic              cycle_is_write_in,   // next cycle is a write
   input  wire dat_mem_t          mem_type_in,         // memory type of space
   input  wire dat_phase_t        phase_in,            // next bus phase
   input  wire logic              addr_last_in,        // last cycle of address
   input  wire logic              single_read_in,      // sdram non-burst read
   input  wire logic              row_hit_in,          // row same as previous
   output var  logic [NUM_CH-1:0] dma_ack_out,         // acknowledge, high
   output var  logic [NUM_CH-1:0] ack_hold_out,        // held past invalid read
   output var  logic              rom_write_err_out    // refused burst rom write
);

   // =====================================================
   // span selection per memory type
   // =====================================================

   // phases during which the ack is asserted, excluding the read hold
   function automatic logic in_span
   (
      input dat_mem_t   mem,
      input dat_phase_t ph,
      input logic       wr,
      input logic       hit
   );
      logic r;
      r = 1'h0;
      case (mem)
         DAT_MEM_ORD,
         DAT_MEM_PSRAM,
         DAT_MEM_BROM:
            r = (ph == DAT_PH_ADDR);
         DAT_MEM_SDRAM_AP:
            if (wr)
               r = (ph == DAT_PH_ROW) | (ph == DAT_PH_COL);
            else
               r = (ph == DAT_PH_ROW) | (ph == DAT_PH_RDCMD) |
                   (ph == DAT_PH_WAIT) | (ph == DAT_PH_RDADDR);
         DAT_MEM_SDRAM_BA:
            if (wr && hit)
               r = (ph == DAT_PH_WAIT) | (ph == DAT_PH_COL);
            else if (wr)
               r = (ph == DAT_PH_PRE) | (ph == DAT_PH_ROW) |
                   (ph == DAT_PH_WAIT) | (ph == DAT_PH_COL);
            else if (hit)
               r = (ph == DAT_PH_RDCMD) | (ph == DAT_PH_WAIT) |
                   (ph == DAT_PH_RDADDR);
            else
               r = (ph == DAT_PH_PRE) | (ph == DAT_PH_ROW) |
                   (ph == DAT_PH_RDCMD) | (ph == DAT_PH_WAIT) |
                   (ph == DAT_PH_RDADDR);
         DAT_MEM_DRAM:
            r = (ph == DAT_PH_ROW) | (ph == DAT_PH_COL);
         default:
            r = 1'h0;
      endcase
      return r;
   endfunction

   // phase that closes an address of the span; only here does the
   // half-cycle early drop apply
   function automatic logic is_closing
   (
      input dat_phase_t ph
   );
      return (ph == DAT_PH_ADDR) | (ph == DAT_PH_RDADDR) | (ph == DAT_PH_COL);
   endfunction

   // =====================================================
   // shared decode
   // =====================================================

   wire logic sdram_space;
   wire logic span_hit;
   wire logic closing_ph;
   wire logic rom_wr_refused;
   wire logic write_addr_start;
   wire logic invalid_read_end;

   assign sdram_space = (mem_type_in == DAT_MEM_SDRAM_AP) |
                        (mem_type_in == DAT_MEM_SDRAM_BA);

   // RULE7 RULE9 RULE10 RULE11 RULE12 RULE13 RULE14 RULE15 RULE16
   assign span_hit = in_span(mem_type_in, phase_in, cycle_is_write_in, row_hit_in);

   assign closing_ph = is_closing(phase_in);

   // dual-mode writes into burst rom get no ack and raise the error flag
   assign rom_wr_refused = dma_cycle_in & cycle_is_write_in & ~single_addr_mode_in &
                           (mem_type_in == DAT_MEM_BROM);  // RULE16

   // the write address that ends a held ack
   assign write_addr_start = dma_cycle_in & cycle_is_write_in &
                             (phase_in != DAT_PH_IDLE);  // RULE8

   // last read address cycle of a single sdram read
   assign invalid_read_end = sdram_space & ~cycle_is_write_in & single_read_in &
                             (phase_in == DAT_PH_RDADDR) & addr_last_in;  // RULE8

   // =====================================================
   // per channel ack generation
   // =====================================================

   logic [NUM_CH-1:0] ack_q;
   logic [NUM_CH-1:0] ack_d;
   logic [NUM_CH-1:0] last_q;
   logic [NUM_CH-1:0] last_d;
   logic [NUM_CH-1:0] hold_q;
   logic [NUM_CH-1:0] hold_d;
   logic [NUM_CH-1:0] drop_half;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch = ch + 1)
      begin : g_ch
         wire logic own_cycle;
         wire logic dir_match;
         wire logic window;
         wire logic hold_set;

         assign own_cycle = dma_cycle_in & (dma_channel_in == CH_W'(ch));  // RULE20

         // single address mode: the one bus cycle always carries the ack
         assign dir_match = single_addr_mode_in |  // RULE18
                            (ack_cycle_select_in[ch] == cycle_is_write_in);  // RULE1 RULE17

         // same qualification for read and write, so ordinary timing matches
         assign window = own_cycle & dir_match & span_hit & ~rom_wr_refused;  // RULE4 RULE20

         assign hold_set = window & invalid_read_end;  // RULE8

         always_comb
         begin
            hold_d[ch] = hold_q[ch];
            if (hold_set)
               hold_d[ch] = 1'h1;
            else if (write_addr_start)
               hold_d[ch] = 1'h0;  // RULE8
         end

         // every address of a split access is its own window with its own
         // closing cycle, giving one pulse per address
         // RULE5 RULE6
         assign ack_d[ch] = window | (hold_q[ch] & ~write_addr_start);  // RULE8

         // drop early only on the final cycle of the address; waits keep
         // addr_last low and so lengthen the ack
         assign last_d[ch] = window & closing_ph & addr_last_in & ~hold_set;  // RULE2 RULE3

         always_ff @(posedge ref_clk_in)
         begin
            if (srst_in)
            begin
               ack_q[ch]  <= 1'h0;
               last_q[ch] <= 1'h0;
               hold_q[ch] <= 1'h0;
            end
            else
            begin
               ack_q[ch]  <= ack_d[ch];
               last_q[ch] <= last_d[ch];
               hold_q[ch] <= hold_d[ch];
            end
         end

         dat_half_drop u_drop
         (
            .ref_clk_in (ref_clk_in),
            .srst_in    (srst_in),
            .last_in    (last_q[ch]),
            .drop_out   (drop_half[ch])
         );
      end
   endgenerate

   // =====================================================
   // outputs
   // =====================================================

   logic err_q;

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
         err_q <= 1'h0;
      else
         err_q <= rom_wr_refused;  // RULE16
   end

   // ack drops in the second half of the closing cycle
   always_comb
   begin
      dma_ack_out = ack_q & ~drop_half;  // RULE2 RULE19
   end

   always_comb
   begin
      ack_hold_out      = hold_q;
      rom_write_err_out = err_q;
   end

endmodule // dat_ack_gen

`default_nettype wire

//--- pkg/dat_consts.svh
//Function
//[RULE1] ack follows the dma address in the read or write cycle chosen per channel
//[RULE2] ack rises with the address and falls half a cycle before it ends
//[RULE3] wait states stretching the address stretch the ack equally
//[RULE4] ordinary space timing is the same for read-cycle and write-cycle ack
//[RULE5] split accesses to narrow devices give one ack pulse per address
//[RULE6] split accesses to sdram, dram, psram, burst rom ack every address too
//[RULE7] auto-precharge sdram read ack spans row, command, wait, read address
//[RULE8] sdram single read ack holds past the invalid read until write address
//[RULE9] auto-precharge sdram write ack spans row and column address
//[RULE10] bank-active sdram read, same row: span command, wait, read address
//[RULE11] bank-active sdram read, new row: precharge, row, command, wait, address
//[RULE12] bank-active sdram write, same row: span wait and column address only
//[RULE13] bank-active sdram write, new row: precharge, row, wait, column address
//[RULE14] dram ack spans row and column address phases
//[RULE15] pseudo-sram ack tracks the address for reads, writes and bursts
//[RULE16] burst rom ack tracks the address; dual-mode writes there are refused
//[RULE17] dual address mode acks in read or write cycle as selected
//[RULE18] single address mode acks the device during the one bus cycle
//[RULE19] the early drop comes from a register on the falling clock edge
//[RULE20] ack stays low in cycles not belonging to the channel's chosen cycle
`ifndef DAT_CONSTS_SVH
`define DAT_CONSTS_SVH

`define DAT_NUM_CH         2
`define DAT_CLK_PERIOD_PS  8000
`define DAT_EARLY_DROP_PS  4000
`define DAT_EARLY_DROP_HALF_CYC ((2 * `DAT_EARLY_DROP_PS) / `DAT_CLK_PERIOD_PS)
`define DAT_SEL_READ       1'h0
`define DAT_SEL_WRITE      1'h1

`endif

//--- pkg/dat_pkg.sv
package dat_pkg;

   // memory type of the space being accessed
   typedef enum logic [2:0] {
      DAT_MEM_ORD,
      DAT_MEM_SDRAM_AP,
      DAT_MEM_SDRAM_BA,
      DAT_MEM_DRAM,
      DAT_MEM_PSRAM,
      DAT_MEM_BROM
   } dat_mem_t;

   // bus phase announced by the bus sequencer for the coming cycle
   typedef enum logic [2:0] {
      DAT_PH_IDLE,
      DAT_PH_ADDR,
      DAT_PH_PRE,
      DAT_PH_ROW,
      DAT_PH_RDCMD,
      DAT_PH_WAIT,
      DAT_PH_RDADDR,
      DAT_PH_COL
   } dat_phase_t;

endpackage

//--- src/dat_half_drop.sv
`timescale 1ns/1ps
`default_nettype none

// falling-edge half of the early deassertion: drop_out is high in the
// second half of a cycle flagged as the last cycle of an ack span
module dat_half_drop
(
   input  wire logic ref_clk_in,  // bus clock
   input  wire logic srst_in,     // synchronous reset
   input  wire logic last_in,     // registered: this cycle ends the span
   output var  logic drop_out     // high in second half of that cycle
);

   logic tog_q;
   logic tog_neg_q;

   // =====================================================
   // rising edge toggles every cycle, so the pair differs in the first half
   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
         tog_q <= 1'h0;
      else
         tog_q <= ~tog_q;
   end

   // =====================================================
   // falling edge catches up, so the match opens mid-cycle
   always_ff @(negedge ref_clk_in)
   begin
      if (srst_in)
         tog_neg_q <= 1'h0;
      else
         tog_neg_q <= tog_q;  // RULE19
   end

   always_comb
   begin
      drop_out = last_in & (tog_q == tog_neg_q);  // RULE19
   end

endmodule // dat_half_drop

`default_nettype wire

//--- tb/dat_ack_gen_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dat_ack_gen_checker
   import dat_pkg::*;
#(
   parameter int NUM_CH = 2,
   parameter int CH_W   = 1
)
(
   input wire logic              ref_clk_in,
   input wire logic              srst_in,
   input wire logic [NUM_CH-1:0] ack_cycle_select_in,
   input wire logic              single_addr_mode_in,
   input wire logic              dma_cycle_in,
   input wire logic [CH_W-1:0]   dma_channel_in,
   input wire logic              cycle_is_write_in,
   input wire dat_mem_t          mem_type_in,
   input wire dat_phase_t        phase_in,
   input wire logic              addr_last_in,
   input wire logic              single_read_in,
   input wire logic              row_hit_in,
   input wire logic [NUM_CH-1:0] dma_ack_out,
   input wire logic [NUM_CH-1:0] ack_hold_out,
   input wire logic              rom_write_err_out
);
   // cycle belongs to the channel's chosen direction
   wire logic own = dma_cycle_in
      && (single_addr_mode_in || cycle_is_write_in == ack_cycle_select_in[dma_channel_in]);
   wire logic go  = own && ack_hold_out == '0;
   wire logic ord = go && mem_type_in == DAT_MEM_ORD && phase_in == DAT_PH_ADDR;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   sequence s_held;
      ack_hold_out[0] && dma_ack_out[0];
   endsequence
   ord_rise_a: assert property (ord && !addr_last_in |=> dma_ack_out[$past(dma_channel_in)])
      else $error("ack low in address cycle");
   ord_drop_a: assert property (ord && addr_last_in |=> !dma_ack_out[$past(dma_channel_in)])
      else $error("ack not dropped before address end");
   ack_quiet_a: assert property (!own && ack_hold_out == '0 |=> dma_ack_out == '0)
      else $error("ack in foreign cycle");
   rom_refuse_a: assert property (go && cycle_is_write_in && !single_addr_mode_in
      && mem_type_in == DAT_MEM_BROM |=> dma_ack_out == '0 ##[0:1] rom_write_err_out)
      else $error("rom write not refused");
   pre_span_a: assert property (go && mem_type_in == DAT_MEM_SDRAM_BA && phase_in == DAT_PH_PRE
      |=> dma_ack_out[$past(dma_channel_in)] != $past(row_hit_in))
      else $error("precharge ack wrong");
   row_span_a: assert property (go && phase_in == DAT_PH_ROW && (mem_type_in == DAT_MEM_DRAM
      || mem_type_in == DAT_MEM_SDRAM_AP) |=> dma_ack_out[$past(dma_channel_in)])
      else $error("row phase not acked");
   hold_set_a: assert property (go && dma_channel_in == '0 && single_read_in && !cycle_is_write_in
      && mem_type_in == DAT_MEM_SDRAM_AP && phase_in == DAT_PH_RDADDR && addr_last_in |=> s_held)
      else $error("ack not held after single read");
   hold_keep_a: assert property (ack_hold_out[0] && phase_in == DAT_PH_IDLE |=> s_held)
      else $error("held ack lost");
   hold_end_a: assert property (ack_hold_out[0] && dma_cycle_in && cycle_is_write_in && !own
      && phase_in != DAT_PH_IDLE |=> !dma_ack_out[0])
      else $error("held ack not ended at write");
endmodule // dat_ack_gen_checker
bind dat_ack_gen dat_ack_gen_checker #(.NUM_CH(NUM_CH), .CH_W(CH_W)) u_chk (.*);
`default_nettype wire

//--- tb/dat_ack_peer.sv
`timescale 1ns/1ps
`default_nettype none
// acknowledged device: counts pulses and notes whether the last fall was mid-cycle
module dat_ack_peer
(
   input  wire logic ref_clk_in, // bus clock
   input  wire logic ack_in,     // acknowledge seen
   output var  int   pulses_out, // pulses counted
   output var  logic mid_out     // last fall at falling clock edge
);
   logic prev_q = 1'b0;
   initial pulses_out = 0;
   initial mid_out = 1'b0;
   // each clock edge samples the half cycle just ended, so zero-time glitches never count
   always @(ref_clk_in)
   begin
      if (ack_in === 1'b1 && !prev_q) pulses_out <= pulses_out + 1;
      if (ack_in !== 1'b1 && prev_q) mid_out <= ref_clk_in;
      prev_q <= (ack_in === 1'b1);
   end
endmodule // dat_ack_peer
`default_nettype wire

//--- tb/dat_ack_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dat_ack_gen_tb;
   import dat_pkg::*;
   logic       ref_clk_in = 1'b0, srst_in = 1'b1, single_addr_mode_in = 1'b0;
   logic       dma_cycle_in = 1'b0, cycle_is_write_in = 1'b0, addr_last_in = 1'b0;
   logic       single_read_in = 1'b0, row_hit_in = 1'b0, rom_write_err_out, mid;
   logic       err_seen = 1'b0;
   logic [0:0] dma_channel_in = '0;
   logic [1:0] ack_cycle_select_in = '0, dma_ack_out, ack_hold_out, p1 = '0, p2 = '0;
   dat_mem_t   mem_type_in = DAT_MEM_ORD;
   dat_phase_t phase_in = DAT_PH_IDLE;
   int         n_mismatch = 0, n_checks = 0, pulses, base;
   always #4 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) if (rom_write_err_out === 1'b1) err_seen <= 1'b1;
   dat_ack_gen dut (.*);
   dat_ack_peer u_peer (.ref_clk_in(ref_clk_in), .ack_in(dma_ack_out[0]),
                        .pulses_out(pulses), .mid_out(mid));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cfg(input logic [1:0] s, input logic a, r, h);
      @(posedge ref_clk_in);
      ack_cycle_select_in <= s;
      single_addr_mode_in <= a;
      single_read_in <= r;
      row_hit_in <= h;
   endtask
   // presents the next cycle, then checks both halves of the one just taken
   task automatic cyc(input logic d, c, w, input dat_mem_t m, input dat_phase_t p,
                      input logic l, input logic [1:0] e1, e2);
      @(posedge ref_clk_in);
      dma_cycle_in <= d;
      dma_channel_in <= c;
      cycle_is_write_in <= w;
      mem_type_in <= m;
      phase_in <= p;
      addr_last_in <= l;
      #2 chk("ack first half", p1, dma_ack_out);
      #4 chk("ack second half", p2, dma_ack_out);
      p1 = e1;
      p2 = e2;
   endtask
   task automatic idle();
      cyc(0, 0, 0, DAT_MEM_ORD, DAT_PH_IDLE, 0, 2'h0, 2'h0);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      for (int s = 0; s < 2; s++)
      begin
         cfg(2'(s), 0, 0, 0);
         cyc(1, 0, s[0], DAT_MEM_ORD, DAT_PH_ADDR, 0, 2'h1, 2'h1);
         cyc(1, 0, s[0], DAT_MEM_ORD, DAT_PH_ADDR, 1, 2'h1, 2'h0);
         cyc(1, 0, !s[0], DAT_MEM_ORD, DAT_PH_ADDR, 1, 2'h0, 2'h0);
         cyc(0, 0, s[0], DAT_MEM_ORD, DAT_PH_ADDR, 0, 2'h0, 2'h0);
         idle();
      end
      cfg(2'h0, 0, 0, 0);
      base = pulses;
      repeat (4) cyc(1, 0, 0, DAT_MEM_ORD, DAT_PH_ADDR, 1, 2'h1, 2'h0);
      repeat (2) cyc(1, 0, 0, DAT_MEM_PSRAM, DAT_PH_ADDR, 1, 2'h1, 2'h0);
      cyc(1, 1, 0, DAT_MEM_PSRAM, DAT_PH_ADDR, 1, 2'h2, 2'h0);
      cyc(1, 0, 0, DAT_MEM_BROM, DAT_PH_ADDR, 1, 2'h1, 2'h0);
      idle();
      chk("pulse count", 7, pulses - base);
      chk("mid drop", 1, mid);
      cfg(2'h0, 1, 0, 0);
      cyc(1, 0, 1, DAT_MEM_ORD, DAT_PH_ADDR, 1, 2'h1, 2'h0);
      idle();
      cfg(2'h1, 0, 0, 0);
      cyc(1, 0, 1, DAT_MEM_BROM, DAT_PH_ADDR, 1, 2'h0, 2'h0);
      cyc(1, 0, 1, DAT_MEM_SDRAM_AP, DAT_PH_ROW, 0, 2'h1, 2'h1);
      cyc(1, 0, 1, DAT_MEM_SDRAM_AP, DAT_PH_COL, 1, 2'h1, 2'h0);
      cyc(1, 0, 1, DAT_MEM_DRAM, DAT_PH_ROW, 0, 2'h1, 2'h1);
      cyc(1, 0, 1, DAT_MEM_DRAM, DAT_PH_COL, 1, 2'h1, 2'h0);
      idle();
      chk("rom refusal", 1, err_seen);
      for (int w = 0; w < 2; w++)
         for (int h = 0; h < 2; h++)
         begin
            cfg(2'(w), 0, 0, h[0]);
            cyc(1, 0, w[0], DAT_MEM_SDRAM_BA, DAT_PH_PRE, 0, 2'(1-h), 2'(1-h));
            cyc(1, 0, w[0], DAT_MEM_SDRAM_BA, DAT_PH_ROW, 0, 2'(1-h), 2'(1-h));
            if (w == 0) cyc(1, 0, 0, DAT_MEM_SDRAM_BA, DAT_PH_RDCMD, 0, 2'h1, 2'h1);
            cyc(1, 0, w[0], DAT_MEM_SDRAM_BA, DAT_PH_WAIT, 0, 2'h1, 2'h1);
            cyc(1, 0, w[0], DAT_MEM_SDRAM_BA, w ? DAT_PH_COL : DAT_PH_RDADDR, 1, 2'h1, 2'h0);
            idle();
         end
      cfg(2'h0, 0, 1, 0);
      cyc(1, 0, 0, DAT_MEM_SDRAM_AP, DAT_PH_ROW, 0, 2'h1, 2'h1);
      cyc(1, 0, 0, DAT_MEM_SDRAM_AP, DAT_PH_RDCMD, 0, 2'h1, 2'h1);
      cyc(1, 0, 0, DAT_MEM_SDRAM_AP, DAT_PH_WAIT, 0, 2'h1, 2'h1);
      cyc(1, 0, 0, DAT_MEM_SDRAM_AP, DAT_PH_RDADDR, 1, 2'h1, 2'h1);
      cyc(0, 0, 0, DAT_MEM_ORD, DAT_PH_IDLE, 0, 2'h1, 2'h1);
      cyc(1, 0, 1, DAT_MEM_ORD, DAT_PH_ADDR, 1, 2'h0, 2'h0);
      idle();
      chk("hold cleared", 0, ack_hold_out);
      wrap_up();
   end
endmodule // dat_ack_gen_tb
`default_nettype wire
